// *** design/swrb_engine.sv ***
// reset/presence and single time-slot engine of the host-to-single-wire bridge
`timescale 1ns/1ns
module swrb_engine
  import swrb_pkg::*;
#(
  parameter int STD_RSTL = STD_RSTL_CYC,
  parameter int STD_RSTH = STD_RSTH_CYC,
  parameter int STD_MSP  = STD_MSP_CYC,
  parameter int STD_SLOT = STD_SLOT_CYC,
  parameter int STD_W0L  = STD_W0L_CYC,
  parameter int OD_RSTL  = OD_RSTL_CYC,
  parameter int OD_RSTH  = OD_RSTH_CYC
)(
  // clock and reset
  input  wire logic         clock,
  input  wire logic         reset,
  // command port from the host-bus front end
  input  wire logic         cmd_strobe,
  input  wire logic [7:0]   cmd_code,
  input  wire logic         param_strobe,
  input  wire logic [7:0]   param_byte,
  output logic              cmd_ack,
  output logic              param_ack,
  output logic              select_status,
  // configuration and status
  input  wire swrb_config_t config_bits,
  output swrb_status_t      status,
  // single-wire line, open drain: enable high pulls low
  input  wire logic         line_in,
  output logic              line_out,
  output logic              line_oe,
  output logic              strong_pullup_on,
  output logic              active_pullup_on
);

  ////////////////////////////////////////////////////////////////////////////
  // state and timer
  swrb_state_t          state;
  swrb_state_t          next_state;
  swrb_status_t         next_status;
  swrb_config_t         cfg;
  swrb_config_t         next_cfg;
  logic                 slot_value;
  logic                 next_slot_value;
  logic                 next_cmd_ack;
  logic                 next_param_ack;
  logic                 next_select_status;
  logic                 next_line_oe;
  logic                 next_strong_pullup_on;
  logic                 next_active_pullup_on;
  logic                 restart;
  logic [ELAPSED_W-1:0] elapsed;

  swrb_timer u_timer (
    .clock   (clock),
    .reset   (reset),
    .restart (restart),
    .elapsed (elapsed)
  );

  ////////////////////////////////////////////////////////////////////////////
  // timing set picked by the speed bit latched at command start
  logic [ELAPSED_W-1:0] t_rstl, t_rsth, t_msp, t_si, t_slot, t_msr, t_low;

  always_comb begin
    if (cfg.overdrive_speed_select) begin
      t_rstl = ELAPSED_W'(OD_RSTL);
      t_rsth = ELAPSED_W'(OD_RSTH);
      t_msp  = ELAPSED_W'(OD_MSP_CYC);
      t_si   = ELAPSED_W'(OD_SI_CYC);
      t_slot = ELAPSED_W'(OD_SLOT_CYC);
      t_msr  = ELAPSED_W'(OD_MSR_CYC);
      t_low  = slot_value ? ELAPSED_W'(OD_W1L_CYC) : ELAPSED_W'(OD_W0L_CYC);
    end else begin
      t_rstl = ELAPSED_W'(STD_RSTL);
      t_rsth = ELAPSED_W'(STD_RSTH);
      t_msp  = ELAPSED_W'(STD_MSP);
      t_si   = ELAPSED_W'(STD_SI_CYC);
      t_slot = ELAPSED_W'(STD_SLOT);
      t_msr  = ELAPSED_W'(STD_MSR_CYC);
      t_low  = slot_value ? ELAPSED_W'(STD_W1L_CYC) : ELAPSED_W'(STD_W0L);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command decode and bus sequencing
  always_comb begin
    next_state         = state;
    next_status        = status;
    next_cfg           = cfg;
    next_slot_value    = slot_value;
    next_cmd_ack       = 1'b0;
    next_param_ack     = 1'b0;
    next_select_status = 1'b0;
    restart            = 1'b0;
    unique case (state)
      ST_IDLE: begin
        // busy is low here, so a code is only refused by being a foreign one
        if (cmd_strobe && cmd_code == CMD_BUS_RESET) begin
          next_cmd_ack       = 1'b1;
          next_select_status = 1'b1;
          next_cfg           = config_bits;
          next_status.line_busy_flag = 1'b1;
          restart            = 1'b1;
          next_state         = ST_RESET_LOW;
        end else if (cmd_strobe && cmd_code == CMD_SINGLE_SLOT) begin
          next_cmd_ack = 1'b1;
          next_state   = ST_WAIT_PARAM;
        end
      end
      ST_WAIT_PARAM: begin
        if (param_strobe) begin
          next_param_ack     = 1'b1;
          next_select_status = 1'b1;
          next_slot_value    = param_byte[SLOT_VALUE_BIT];
          next_cfg           = config_bits;
          next_status.line_busy_flag = 1'b1;
          restart            = 1'b1;
          next_state         = ST_SLOT;
        end
      end
      ST_RESET_LOW: begin
        if (elapsed == t_rstl - 1'b1) begin
          restart    = 1'b1;
          next_state = ST_RESET_HIGH;
        end
      end
      ST_RESET_HIGH: begin
        // a line still low at the short sample means a shorted bus
        if (elapsed == t_si) begin
          next_status.short_detect_flag = ~line_in;
        end
        if (elapsed == t_msp) begin
          next_status.presence_pulse_flag = ~line_in;
        end
        if (elapsed == t_rsth - 1'b1) begin
          next_status.line_busy_flag = 1'b0;
          next_state = ST_IDLE;
        end
      end
      ST_SLOT: begin
        if (elapsed == t_msr) begin
          next_status.single_bit_result    = line_in;
          next_status.branch_direction_bit = line_in;
        end
        if (elapsed == t_slot - 1'b1) begin
          next_status.line_busy_flag = 1'b0;
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // line drive and pullups, decoded from next_state so they register in step with the state
  always_comb begin
    next_line_oe          = 1'b0;
    next_strong_pullup_on = 1'b0;
    next_active_pullup_on = 1'b0;
    if (next_state == ST_RESET_LOW) begin
      next_line_oe = 1'b1;
    end else if (next_state == ST_SLOT && state == ST_SLOT) begin
      next_line_oe = (elapsed + 1'b1) < t_low;
    end else if (next_state == ST_SLOT) begin
      next_line_oe = 1'b1;
    end
    // pullups only help while the engine owns the bus and lets it rise
    if (next_state inside {ST_RESET_HIGH, ST_SLOT} && !next_line_oe) begin
      next_active_pullup_on = next_cfg.active_pullup_enable;
      next_strong_pullup_on = next_cfg.strong_pullup_enable;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state            <= ST_IDLE;
      status           <= '{default: RESET_FLAG};
      cfg              <= '{default: RESET_FLAG};
      slot_value       <= RESET_FLAG;
      cmd_ack          <= RESET_FLAG;
      param_ack        <= RESET_FLAG;
      select_status    <= RESET_FLAG;
      line_out         <= RESET_FLAG;
      line_oe          <= RESET_FLAG;
      strong_pullup_on <= RESET_FLAG;
      active_pullup_on <= RESET_FLAG;
    end else begin
      state            <= next_state;
      status           <= next_status;
      cfg              <= next_cfg;
      slot_value       <= next_slot_value;
      cmd_ack          <= next_cmd_ack;
      param_ack        <= next_param_ack;
      select_status    <= next_select_status;
      line_out         <= RESET_FLAG;
      line_oe          <= next_line_oe;
      strong_pullup_on <= next_strong_pullup_on;
      active_pullup_on <= next_active_pullup_on;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence reset_taken_s;
    state == ST_IDLE && cmd_strobe && cmd_code == CMD_BUS_RESET;
  endsequence

  sequence slot_taken_s;
    state == ST_WAIT_PARAM && param_strobe;
  endsequence

  busy_code_drop_a: assert property (status.line_busy_flag && cmd_strobe |=> !cmd_ack)
    else $error("code acknowledged while busy");
  busy_param_drop_a: assert property (status.line_busy_flag && param_strobe |=> !param_ack)
    else $error("parameter acknowledged while busy");
  reset_start_a: assert property (reset_taken_s |=> line_oe && status.line_busy_flag && cmd_ack)
    else $error("reset did not start bus activity");
  reset_busy_a: assert property (reset_taken_s |=> status.line_busy_flag[*8])
    else $error("busy dropped early in reset");
  slot_start_a: assert property (slot_taken_s |=> line_oe && status.line_busy_flag && param_ack)
    else $error("slot did not start bus activity");
  pointer_move_a: assert property (reset_taken_s or slot_taken_s |=> select_status)
    else $error("read pointer not moved to status");
  idle_release_a: assert property (state == ST_IDLE |-> !line_oe)
    else $error("line pulled low while idle");
  msr_sample_a: assert property (state == ST_SLOT && elapsed == t_msr
                                 |=> status.single_bit_result == $past(line_in))
    else $error("slot result not sampled");
  presence_sample_a: assert property (state == ST_RESET_HIGH && elapsed == t_msp
                                      |=> status.presence_pulse_flag == !$past(line_in))
    else $error("presence not sampled");
  busy_state_a: assert property (status.line_busy_flag ==
                                 (state inside {ST_RESET_LOW, ST_RESET_HIGH, ST_SLOT}))
    else $error("busy flag out of step with activity");

endmodule

// *** design/swrb_pkg.sv ***
// package: command codes, timing constants and carrier structs of the reset and bit-slot engine
package swrb_pkg;

  // command codes and the parameter byte field
  localparam logic [7:0] CMD_BUS_RESET   = 8'hB4;
  localparam logic [7:0] CMD_SINGLE_SLOT = 8'h87;
  localparam int         SLOT_VALUE_BIT  = 7;

  // clock rate and counter width
  localparam int CLOCK_PERIOD_NS = 10;
  localparam int ELAPSED_W       = 18;

  // latest start of bus activity after the triggering host-bus edge
  localparam int START_MAX_PS  = 262500;
  localparam int START_MAX_CYC = START_MAX_PS / (CLOCK_PERIOD_NS * 1000);

  // standard-speed times in ns (plain defaults)
  localparam int STD_RSTL_NS = 560000;
  localparam int STD_RSTH_NS = 560000;
  localparam int STD_MSP_NS  = 70000;
  localparam int STD_SI_NS   = 8000;
  localparam int STD_SLOT_NS = 70000;
  localparam int STD_MSR_NS  = 13000;
  localparam int STD_W0L_NS  = 60000;
  localparam int STD_W1L_NS  = 6000;

  // overdrive-speed times in ns (plain defaults)
  localparam int OD_RSTL_NS = 70000;
  localparam int OD_RSTH_NS = 70000;
  localparam int OD_MSP_NS  = 10000;
  localparam int OD_SI_NS   = 1000;
  localparam int OD_SLOT_NS = 10000;
  localparam int OD_MSR_NS  = 2000;
  localparam int OD_W0L_NS  = 8000;
  localparam int OD_W1L_NS  = 1000;

  // cycle counts; long ones become top-level parameters
  localparam int STD_RSTL_CYC = STD_RSTL_NS / CLOCK_PERIOD_NS;
  localparam int STD_RSTH_CYC = STD_RSTH_NS / CLOCK_PERIOD_NS;
  localparam int STD_MSP_CYC  = STD_MSP_NS / CLOCK_PERIOD_NS;
  localparam int STD_SI_CYC   = STD_SI_NS / CLOCK_PERIOD_NS;
  localparam int STD_SLOT_CYC = STD_SLOT_NS / CLOCK_PERIOD_NS;
  localparam int STD_MSR_CYC  = STD_MSR_NS / CLOCK_PERIOD_NS;
  localparam int STD_W0L_CYC  = STD_W0L_NS / CLOCK_PERIOD_NS;
  localparam int STD_W1L_CYC  = STD_W1L_NS / CLOCK_PERIOD_NS;
  localparam int OD_RSTL_CYC  = OD_RSTL_NS / CLOCK_PERIOD_NS;
  localparam int OD_RSTH_CYC  = OD_RSTH_NS / CLOCK_PERIOD_NS;
  localparam int OD_MSP_CYC   = OD_MSP_NS / CLOCK_PERIOD_NS;
  localparam int OD_SI_CYC    = OD_SI_NS / CLOCK_PERIOD_NS;
  localparam int OD_SLOT_CYC  = OD_SLOT_NS / CLOCK_PERIOD_NS;
  localparam int OD_MSR_CYC   = OD_MSR_NS / CLOCK_PERIOD_NS;
  localparam int OD_W0L_CYC   = OD_W0L_NS / CLOCK_PERIOD_NS;
  localparam int OD_W1L_CYC   = OD_W1L_NS / CLOCK_PERIOD_NS;

  // reset values
  localparam logic RESET_FLAG = 1'b0;

  // configuration bits fed in from the rest of the bridge
  typedef struct packed {
    logic overdrive_speed_select;
    logic active_pullup_enable;
    logic strong_pullup_enable;
  } swrb_config_t;

  // status bits owned by this engine
  typedef struct packed {
    logic line_busy_flag;
    logic presence_pulse_flag;
    logic short_detect_flag;
    logic single_bit_result;
    logic branch_direction_bit;
  } swrb_status_t;

  // engine states
  typedef enum logic [2:0] {
    ST_IDLE       = 3'h0,
    ST_WAIT_PARAM = 3'h1,
    ST_RESET_LOW  = 3'h2,
    ST_RESET_HIGH = 3'h3,
    ST_SLOT       = 3'h4
  } swrb_state_t;

endpackage

// *** design/swrb_timer.sv ***
// elapsed-cycle counter that restarts on request and saturates at its top
`timescale 1ns/1ns
module swrb_timer
  import swrb_pkg::*;
(
  // clock and reset
  input  wire logic                 clock,
  input  wire logic                 reset,
  // control
  input  wire logic                 restart,
  // count since the last restart
  output logic      [ELAPSED_W-1:0] elapsed
);

  logic [ELAPSED_W-1:0] next_elapsed;

  // saturate so a stalled phase never wraps into a false match
  always_comb begin
    if (restart) begin
      next_elapsed = '0;
    end else if (&elapsed) begin
      next_elapsed = elapsed;
    end else begin
      next_elapsed = elapsed + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      elapsed <= '0;
    end else begin
      elapsed <= next_elapsed;
    end
  end

endmodule

// *** test/swrb_target.sv ***
// behavioural single-wire target: presence pulse after reset and optional zero answer in slots
`timescale 1ns/1ns
module swrb_target (
  // clock and observed line drive
  input  wire logic clock,
  input  wire logic line_oe,
  // behaviour controls, lengths in cycles, zero pres_len or ans_len disables
  input  wire logic [31:0] pres_wait,
  input  wire logic [31:0] pres_len,
  input  wire logic [31:0] ans_len,
  // open-drain pull of the target
  output logic             pull_low
);
  int   lo;
  logic prev;
  ////////////////////////////////////////////////////////////////////////
  // sampled at the falling edge so registered line_oe is settled
  initial begin
    pull_low = 1'b0;
    lo = 0;
    prev = 1'b0;
    forever begin
      @(negedge clock);
      if (prev && !line_oe && lo >= 1500 && pres_len > 0) begin
        repeat (pres_wait) @(negedge clock);
        pull_low = 1'b1; // presence, or a short when the wait is zero
        repeat (pres_len) @(negedge clock);
        pull_low = 1'b0;
      end else if (!prev && line_oe && ans_len > 0) begin
        pull_low = 1'b1; // answer a zero bit in the slot
        repeat (ans_len) @(negedge clock);
        pull_low = 1'b0;
      end
      lo = line_oe ? lo + 1 : 0;
      prev = line_oe;
    end
  end
endmodule

// *** test/tb_top.sv ***
// self-checking bench of the reset and bit-slot engine
`timescale 1ns/1ns
module tb_top;
  import swrb_pkg::*;
  // shortened counts; presence/short samples must still fall inside reset high
  localparam int SRL = 1600, SRH = 1500, SMSP = 1000, SSLOT = 1500, SW0L = 1400, ORL = 1600, ORH = 1200;
  logic         clock, reset, cmd_strobe, param_strobe, cmd_ack, param_ack, select_status;
  logic [7:0]   cmd_code, param_byte;
  swrb_config_t config_bits;
  swrb_status_t status;
  logic         line_in, line_out, line_oe, strong_pullup_on, active_pullup_on, pull_low;
  int           pres_wait, pres_len, ans_len, mismatches, compares, cyc, t0, t_oe;
  int           n_ack, n_pack, n_sel, n_busy, n_oe, n_spu, n_apu, n_out;
  // open drain with passive pullup: released line reads high
  assign line_in = !(line_oe | pull_low);
  swrb_engine #(.STD_RSTL(SRL), .STD_RSTH(SRH), .STD_MSP(SMSP), .STD_SLOT(SSLOT), .STD_W0L(SW0L),
                .OD_RSTL(ORL), .OD_RSTH(ORH)) DUT (
    .clock(clock), .reset(reset), .cmd_strobe(cmd_strobe), .cmd_code(cmd_code),
    .param_strobe(param_strobe), .param_byte(param_byte), .cmd_ack(cmd_ack), .param_ack(param_ack),
    .select_status(select_status), .config_bits(config_bits), .status(status), .line_in(line_in),
    .line_out(line_out), .line_oe(line_oe), .strong_pullup_on(strong_pullup_on),
    .active_pullup_on(active_pullup_on));
  swrb_target target (.clock(clock), .line_oe(line_oe), .pres_wait(pres_wait), .pres_len(pres_len),
                      .ans_len(ans_len), .pull_low(pull_low));
  ////////////////////////////////////////////////////////////////////////
  // clock at 10 ns
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // output activity counters, sampled mid-cycle
  always @(negedge clock) begin
    cyc++;
    n_ack += (cmd_ack === 1'b1);
    n_pack += (param_ack === 1'b1);
    n_sel += (select_status === 1'b1);
    n_busy += (status.line_busy_flag === 1'b1);
    n_oe += (line_oe === 1'b1);
    n_spu += (strong_pullup_on === 1'b1);
    n_apu += (active_pullup_on === 1'b1);
    n_out += (line_out !== 1'b0);
    if (line_oe === 1'b1 && t_oe < 0) t_oe = cyc;
  end
  ////////////////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  // strobe a code and its parameter; used to hit the engine while busy
  task poke(input logic [7:0] c);
    cmd_code = c;
    cmd_strobe = 1'b1;
    @(negedge clock);
    cmd_strobe = 1'b0;
    param_strobe = 1'b1;
    param_byte = 8'h80;
    @(negedge clock);
    param_strobe = 1'b0;
  endtask
  // one command from strobe to busy low, with activity counts checked
  task run(input logic [7:0] c, input logic [7:0] pb, input logic wp, input swrb_config_t cf,
           input int e_ack, input int e_busy, input int e_oe);
    n_ack = 0;
    n_pack = 0;
    n_sel = 0;
    n_busy = 0;
    n_oe = 0;
    n_spu = 0;
    n_apu = 0;
    n_out = 0;
    t_oe = -1;
    @(negedge clock);
    config_bits = cf;
    cmd_code = c;
    cmd_strobe = 1'b1;
    t0 = cyc;
    @(negedge clock);
    cmd_strobe = 1'b0;
    if (wp) begin
      param_byte = pb;
      param_strobe = 1'b1;
      t0 = cyc;
      @(negedge clock);
      param_strobe = 1'b0;
    end
    for (int i = 0; i < 4000; i++) begin
      @(negedge clock);
      if (i > 5 && status.line_busy_flag !== 1'b1) break;
    end
    chk("cmd_ack", e_ack, n_ack);
    chk("param_ack", wp ? e_ack : 0, n_pack);
    chk("select_status", e_ack, n_sel);
    chk("busy_cycles", e_busy, n_busy);
    chk("low_cycles", e_oe, n_oe);
    chk("line_out", 0, n_out);
    if (e_ack > 0) chk("start", 1, t_oe >= t0 && t_oe - t0 <= START_MAX_CYC);
    if (e_ack > 0) chk("apu", cf.active_pullup_enable, n_apu > 0);
    if (e_ack > 0) chk("spu", cf.strong_pullup_enable, n_spu > 0);
  endtask
  task end_sim;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // watchdog well beyond the roughly 16000 cycles of the tests
  initial begin
    repeat (60000) @(posedge clock);
    mismatches++;
    end_sim();
  end
  // slot table: speed, value, target answers, expected sampled bit
  logic [3:0] slots [5] = '{4'b1101, 4'b1110, 4'b1000, 4'b0101, 4'b0000};
  int         an [5] = '{0, 300, 0, 0, 0};
  initial begin
    reset = 1'b1;
    cmd_strobe = 1'b0;
    param_strobe = 1'b0;
    cmd_code = 8'h00;
    param_byte = 8'h00;
    config_bits = '0;
    pres_wait = 300;
    pres_len = 800;
    ans_len = 0;
    mismatches = 0;
    compares = 0;
    cyc = 0;
    t_oe = -1;
    n_out = 0;
    repeat (12) @(negedge clock);
    reset = 1'b0;
    chk("status_reset", 5'h00, status);
    // overdrive reset with a second reset code while busy, strong pullup kept off
    fork
      run(CMD_BUS_RESET, 8'h00, 1'b0, '{1'b1, 1'b1, 1'b0}, 1, ORL + ORH, ORL);
      begin
        repeat (100) @(negedge clock);
        poke(CMD_BUS_RESET);
      end
    join
    chk("presence", 1'b1, status.presence_pulse_flag);
    chk("short", 1'b0, status.short_detect_flag);
    pres_len = 0; // no target answers
    run(CMD_BUS_RESET, 8'h00, 1'b0, '{1'b1, 1'b0, 1'b0}, 1, ORL + ORH, ORL);
    chk("no_presence", 1'b0, status.presence_pulse_flag);
    // line held low at release: a short; let go before reset high ends so no slot sees it
    pres_wait = 0;
    pres_len = 1400;
    run(CMD_BUS_RESET, 8'h00, 1'b0, '{1'b0, 1'b0, 1'b0}, 1, SRL + SRH, SRL);
    chk("short_std", 1'b1, status.short_detect_flag);
    chk("presence_std", 1'b1, status.presence_pulse_flag);
    pres_len = 0;
    // slot code while a slot runs gets no acks at all
    fork
      run(CMD_SINGLE_SLOT, 8'hD5, 1'b1, '{1'b1, 1'b0, 1'b1}, 1, 1000, 100);
      begin
        repeat (100) @(negedge clock);
        poke(CMD_SINGLE_SLOT);
      end
    join
    for (int k = 0; k < 5; k++) begin
      ans_len = slots[k][3] ? an[k] : 1400;
      if (!slots[k][1]) ans_len = 0;
      run(CMD_SINGLE_SLOT, {slots[k][2], 7'h55 ^ 7'(k)}, 1'b1, '{slots[k][3], 1'b1, slots[k][2]}, 1,
          slots[k][3] ? 1000 : SSLOT, slots[k][3] ? (slots[k][2] ? 100 : 800) : (slots[k][2] ? 600 : SW0L));
      chk("bit_result", slots[k][0], status.single_bit_result);
      chk("direction", slots[k][0], status.branch_direction_bit);
    end
    run(8'hA5, 8'h00, 1'b0, '{1'b1, 1'b1, 1'b1}, 0, 0, 0); // unknown codes are refused
    end_sim();
  end
endmodule
